//--- src/supervisor_pkg.sv
// constants and types for the drive set point and fault supervisor
// assumes a single 250 MHz system clock shared by all users of this package
package supervisor_pkg;
   // clock and time figures, each in its own unit; cycle counts derived
   localparam longint CLK_HZ = 250_000_000;
   localparam longint RESTART_WAIT_S = 240;
   localparam longint RESTART_WAIT_CYC = RESTART_WAIT_S * CLK_HZ;
   localparam longint COOL_S = 180;
   localparam longint COOL_CYC = COOL_S * CLK_HZ;
   localparam longint ATTEMPT_MS = 1000;
   localparam longint ATTEMPT_CYC = ATTEMPT_MS * CLK_HZ / 1000;
   localparam longint FLASH_MS = 1000;
   localparam longint FLASH_CYC = FLASH_MS * CLK_HZ / 1000;
   localparam longint PID_TICK_US = 1000;
   localparam longint PID_TICK_CYC = PID_TICK_US * CLK_HZ / 1_000_000;
   // one ramp time unit (0.1 s) spread over the full 16-bit reference scale
   localparam longint RAMP_UNIT_MS = 100;
   localparam logic [15:0] RAMP_UNIT_CYC = 16'(RAMP_UNIT_MS * CLK_HZ / 1000 / 65536);
   localparam int TIMER_W = 36;
   localparam int CNT_W = 32;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_KEYPAD_SP = 8'h04;
   localparam logic [7:0] ADDR_RAMP_TIME = 8'h08;
   localparam logic [7:0] ADDR_GAINS = 8'h0c;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_LOOP = 8'h18;

   // control register layout and reset value
   localparam int CTRL_W = 6;
   localparam int CTRL_CLOSED_LOOP = 0;
   localparam int CTRL_SRC_LSB = 1;
   localparam int CTRL_FB_CURRENT = 3;
   localparam int CTRL_LOOP_LOSS_FAULT = 4;
   localparam int CTRL_EXT_TRIP_CLOSED = 5;
   localparam logic [5:0] CTRL_RESET = 6'h10;
   localparam logic [1:0] SRC_NONE = 2'h0;
   localparam logic [1:0] SRC_VOLTAGE = 2'h1;
   localparam logic [1:0] SRC_CURRENT = 2'h2;
   localparam logic [15:0] RAMP_TIME_RESET = 16'h012c;
   localparam logic [23:0] GAINS_RESET = 24'h000010;
   localparam int CMD_FAULT_RESET = 0;
   localparam int CMD_FACTORY_RESET = 1;
   localparam int STAT_LOCKOUT = 4;
   localparam int STAT_COOLING = 5;
   localparam int STAT_FACTORY = 6;
   localparam int STAT_ANALOG = 7;
   localparam int PID_SHIFT = 4;

   // synchronised pin bit positions
   localparam int SYNC_W = 13;
   localparam int PS_SELECT = 0;
   localparam int PS_EXT_CLOSED = 1;
   localparam int PS_OVERCURRENT = 2;
   localparam int PS_UNDERVOLT = 3;
   localparam int PS_OVERVOLT = 4;
   localparam int PS_LOOP_LOW = 5;
   localparam int PS_SAG = 6;
   localparam int PS_BRAKE = 7;
   localparam int PS_OVERLOAD = 8;
   localparam int PS_ENTER = 9;
   localparam int PS_LOW_FREQ = 10;
   localparam int PS_SW_MISMATCH = 11;
   localparam int PS_LANGUAGE = 12;

   typedef enum logic [3:0] {
      F_NONE, F_OVERCURRENT, F_UNDERVOLT, F_OVERVOLT, F_OVERLOAD, F_SAG,
      F_CONTROL, F_LANGUAGE, F_EXTERNAL, F_BRAKE, F_LOOP_LOSS
   } fault_t;
   typedef enum logic [1:0] {RS_IDLE, RS_WAIT, RS_ATTEMPT, RS_LOCKOUT} restart_t;
   typedef enum logic [1:0] {D_SETPOINT, D_LOAD, D_FEEDBACK} disp_t;
endpackage

//--- src/drive_setpoint_fault_supervisor.sv
// set point selection, set point ramp, closed-loop regulator, display select and fault supervision
// assumes contacts close to the circuit_common_terminal, comparator pins are asynchronous,
// analog values, load and nv restore come from logic on pclk
// Operation
// - select contact closed uses programmed analog input, otherwise keypad reference
// - analog input also assigned as feedback never serves as set point, except source code 3 with current loop feedback
// - reference to regulator ramps toward new set point, both directions
// - ramp time zero applies new set point at once
// - integral term keeps moving speed command while error persists
// - differential term uses change of error, not error itself
// - closed loop: status shows frequency; right field shows set point, load or feedback
// - enter key advances right field cyclically
// - set point and feedback views flash label before value
// - supply sag and control board faults never restart automatically
// - overcurrent below 1.5 Hz: one restart after four minutes
// - failed low-frequency restart enters lockout, cleared only by manual reset
// - overload fault reset refused until three-minute cooling elapsed
// - overload fault and its delay survive power loss
// - output current above 200% trips overcurrent
// - bus below 60% trips undervoltage
// - bus above 120% trips overvoltage
// - current loop below 2 mA with loss action fault trips
// - external contact trips open or closed per its configuration
// - missing display language raises language fault
// - braking resistor overload raises brake fault
//
// Added by the designer: the register offsets and the APB interface to the registers.
module drive_setpoint_fault_supervisor #(
   parameter logic [supervisor_pkg::TIMER_W-1:0] RESTART_WAIT_CYCLES =
      supervisor_pkg::TIMER_W'(supervisor_pkg::RESTART_WAIT_CYC),
   parameter logic [supervisor_pkg::TIMER_W-1:0] COOL_CYCLES = supervisor_pkg::TIMER_W'(supervisor_pkg::COOL_CYC),
   parameter logic [supervisor_pkg::TIMER_W-1:0] ATTEMPT_CYCLES =
      supervisor_pkg::TIMER_W'(supervisor_pkg::ATTEMPT_CYC),
   parameter logic [supervisor_pkg::CNT_W-1:0] FLASH_CYCLES = supervisor_pkg::CNT_W'(supervisor_pkg::FLASH_CYC),
   parameter logic [supervisor_pkg::CNT_W-1:0] PID_TICK_CYCLES = supervisor_pkg::CNT_W'(supervisor_pkg::PID_TICK_CYC)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic setpoint_select_contact_n,
   input wire logic external_fault_contact_n,
   input wire logic overcurrent_detect,
   input wire logic bus_undervoltage_detect,
   input wire logic bus_overvoltage_detect,
   input wire logic current_loop_below_2ma,
   input wire logic control_supply_sag_detect,
   input wire logic brake_resistor_overload,
   input wire logic overload_detect,
   input wire logic enter_key,
   input wire logic output_below_1p5hz,
   input wire logic software_version_mismatch,
   input wire logic language_missing,
   input wire logic [15:0] voltage_analog_input,
   input wire logic [15:0] current_loop_input,
   input wire logic [15:0] output_frequency,
   input wire logic [15:0] load_percent,
   input wire logic nv_overload_restore,
   output logic [15:0] speed_command,
   output logic [15:0] setpoint_reference,
   output logic drive_stop,
   output supervisor_pkg::fault_t fault_code,
   output logic restart_lockout_state,
   output logic overload_persist,
   output logic status_shows_frequency,
   output supervisor_pkg::disp_t right_field_select,
   output logic label_flash,
   output logic [15:0] right_field_value
);
   import supervisor_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic enter_prev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [CTRL_W-1:0] ctrl;
      logic [15:0] keypad_sp;
      logic [15:0] ramp_time;
      logic [23:0] gains;
      logic factory_done;
      logic analog_used;
      logic [15:0] target;
      logic [15:0] ref_val;
      logic [CNT_W-1:0] ramp_cnt;
      logic [CNT_W-1:0] pid_cnt;
      logic signed [16:0] err_prev;
      logic signed [31:0] integ;
      logic [15:0] speed_cmd;
      fault_t fault;
      restart_t rs;
      logic [TIMER_W-1:0] rs_cnt;
      logic cooling;
      logic [TIMER_W-1:0] cool_cnt;
      logic nv_pending;
      disp_t disp;
      logic flash;
      logic [CNT_W-1:0] flash_cnt;
      logic status_freq;
      logic [15:0] right_val;
   } state_t;

   state_t q;
   state_t d;
   logic [SYNC_W-1:0] pins;
   logic access_done;
   logic fault_reset_req;
   logic enter_rise;

   // fixed trip priority when several causes arrive together
   function automatic fault_t first_fault(input logic [SYNC_W-1:0] s, input logic [CTRL_W-1:0] c);
      fault_t f;
      f = F_NONE;
      if (s[PS_BRAKE]) f = F_BRAKE;
      if (s[PS_LANGUAGE]) f = F_LANGUAGE;
      if (s[PS_LOOP_LOW] && c[CTRL_LOOP_LOSS_FAULT]) f = F_LOOP_LOSS;
      if (s[PS_EXT_CLOSED] == c[CTRL_EXT_TRIP_CLOSED]) f = F_EXTERNAL;
      if (s[PS_SW_MISMATCH]) f = F_CONTROL;
      if (s[PS_OVERLOAD]) f = F_OVERLOAD;
      if (s[PS_SAG]) f = F_SAG;
      if (s[PS_OVERVOLT]) f = F_OVERVOLT;
      if (s[PS_UNDERVOLT]) f = F_UNDERVOLT;
      if (s[PS_OVERCURRENT]) f = F_OVERCURRENT;
      return f;
   endfunction

   // analog source may serve only when it is not the feedback input, except source code 3, which takes the current loop input even as feedback
   function automatic logic src_usable(input logic [CTRL_W-1:0] c);
      logic [1:0] src;
      src = c[CTRL_SRC_LSB +: 2];
      return (src == SRC_VOLTAGE && !c[CTRL_FB_CURRENT]) || (src == SRC_CURRENT && c[CTRL_FB_CURRENT]) ? 1'b0 :
         (src != SRC_NONE);
   endfunction

   // contacts are closed when pulled to common, hence the inversions
   assign pins = {language_missing, software_version_mismatch, output_below_1p5hz, enter_key, overload_detect,
      brake_resistor_overload, control_supply_sag_detect, current_loop_below_2ma, bus_overvoltage_detect,
      bus_undervoltage_detect, overcurrent_detect, ~external_fault_contact_n, ~setpoint_select_contact_n};
   assign access_done = psel && penable && q.pready;
   assign fault_reset_req = access_done && pwrite && paddr == ADDR_CMD && pwdata[CMD_FAULT_RESET];
   assign enter_rise = q.sync2[PS_ENTER] && !q.enter_prev;

   // next-state logic for the whole block
   always_comb begin
      logic [15:0] fb;
      logic signed [16:0] err;
      logic signed [33:0] sum;
      fault_t cause;
      logic reset_ok;
      fb = 16'h0;
      err = 17'sh0;
      sum = 34'sh0;
      cause = F_NONE;
      reset_ok = 1'b0;
      d = q;
      d.sync1 = pins;
      d.sync2 = q.sync1;
      d.enter_prev = q.sync2[PS_ENTER];

      // apb: one wait cycle, then pready for the cycle where the transfer completes
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      if (psel && penable && !q.pready) begin
         d.pready = 1'b1;
         d.prdata = 32'h0;
         case (paddr)
            ADDR_CTRL: d.prdata = 32'(q.ctrl);
            ADDR_KEYPAD_SP: d.prdata = 32'(q.keypad_sp);
            ADDR_RAMP_TIME: d.prdata = 32'(q.ramp_time);
            ADDR_GAINS: d.prdata = 32'(q.gains);
            ADDR_CMD: d.prdata = 32'h0;
            ADDR_STATUS: d.prdata = {22'h0, q.rs, q.analog_used, q.factory_done, q.cooling,
               q.rs == RS_LOCKOUT, q.fault};
            ADDR_LOOP: d.prdata = {q.speed_cmd, q.ref_val};
            default: d.pslverr = 1'b1;
         endcase
      end
      if (access_done && pwrite) begin
         case (paddr)
            ADDR_CTRL: d.ctrl = pwdata[CTRL_W-1:0];
            ADDR_KEYPAD_SP: d.keypad_sp = pwdata[15:0];
            ADDR_RAMP_TIME: d.ramp_time = pwdata[15:0];
            ADDR_GAINS: d.gains = pwdata[23:0];
            ADDR_CMD: if (pwdata[CMD_FACTORY_RESET]) d.factory_done = 1'b1;
            default: d.ctrl = q.ctrl;
         endcase
      end

      // set point source: analog only with the select contact closed
      d.analog_used = q.sync2[PS_SELECT] && src_usable(q.ctrl);
      d.target = q.keypad_sp;
      if (q.sync2[PS_SELECT] && src_usable(q.ctrl)) begin
         d.target = q.ctrl[CTRL_SRC_LSB +: 2] == SRC_VOLTAGE ? voltage_analog_input : current_loop_input;
      end

      // ramp one lsb per step; step period scales with the ramp time setting
      if (q.ramp_time == 16'h0) begin
         d.ref_val = q.target;
         d.ramp_cnt = '0;
      end else if (q.ramp_cnt >= CNT_W'(q.ramp_time) * CNT_W'(RAMP_UNIT_CYC)) begin
         d.ramp_cnt = '0;
         if (q.ref_val < q.target) d.ref_val = q.ref_val + 16'h1;
         else if (q.ref_val > q.target) d.ref_val = q.ref_val - 16'h1;
      end else begin
         d.ramp_cnt = q.ramp_cnt + 1'b1;
      end

      // regulator sampled on a slow tick; integral clamped to avoid wrap
      fb = q.ctrl[CTRL_FB_CURRENT] ? current_loop_input : voltage_analog_input;
      err = $signed({1'b0, q.ref_val}) - $signed({1'b0, fb});
      d.pid_cnt = q.pid_cnt + 1'b1;
      if (q.pid_cnt >= PID_TICK_CYCLES - 1'b1) begin
         d.pid_cnt = '0;
         d.err_prev = err;
         sum = 34'(q.integ) + 34'(err) * 34'($signed({1'b0, q.gains[15:8]}));
         if (sum > 34'sh7fffffff) sum = 34'sh7fffffff;
         if (sum < -34'sh80000000) sum = -34'sh80000000;
         d.integ = 32'(sum);
         sum = 34'(err) * 34'($signed({1'b0, q.gains[7:0]})) + 34'(q.integ)
            + (34'(err) - 34'(q.err_prev)) * 34'($signed({1'b0, q.gains[23:16]}));
         sum = sum >>> PID_SHIFT;
         d.speed_cmd = sum < 0 ? 16'h0 : (sum > 34'sh0ffff ? 16'hffff : sum[15:0]);
      end

      // fault reset permission: overload waits for cooling, control needs factory reset
      reset_ok = !(q.fault == F_OVERLOAD && q.cooling)
         && !(q.fault == F_CONTROL && !q.factory_done);
      if (q.cooling) begin
         d.cool_cnt = q.cool_cnt + 1'b1;
         if (q.cool_cnt >= COOL_CYCLES - 1'b1) d.cooling = 1'b0;
      end
      if (fault_reset_req && reset_ok) begin
         if (q.fault == F_CONTROL) d.factory_done = 1'b0;
         d.fault = F_NONE;
         d.rs = RS_IDLE;
      end

      // automatic restart only on low-frequency overcurrent; sag and control stay latched
      case (q.rs)
         RS_IDLE: d.rs_cnt = '0;
         RS_WAIT: begin
            d.rs_cnt = q.rs_cnt + 1'b1;
            if (q.rs_cnt >= RESTART_WAIT_CYCLES - 1'b1 && q.fault == F_OVERCURRENT) begin
               d.fault = F_NONE;
               d.rs = RS_ATTEMPT;
               d.rs_cnt = '0;
            end
         end
         RS_ATTEMPT: begin
            d.rs_cnt = q.rs_cnt + 1'b1;
            if (q.rs_cnt >= ATTEMPT_CYCLES - 1'b1) d.rs = RS_IDLE;
         end
         RS_LOCKOUT: d.rs_cnt = '0;
         default: d.rs = RS_IDLE;
      endcase

      // latch the first trip; a cause present with a reset wins over it
      cause = first_fault(q.sync2, q.ctrl);
      if (cause != F_NONE && (q.fault == F_NONE || d.fault == F_NONE)) begin
         d.fault = cause;
         if (cause == F_OVERLOAD) begin
            d.cooling = 1'b1;
            d.cool_cnt = '0;
         end
         if (cause == F_OVERCURRENT && q.rs == RS_ATTEMPT) d.rs = RS_LOCKOUT;
         else if (cause == F_OVERCURRENT && q.sync2[PS_LOW_FREQ] && q.rs == RS_IDLE) d.rs = RS_WAIT;
         else if (q.rs != RS_LOCKOUT) d.rs = RS_IDLE;
      end

      // stored overload restarts its full delay after power returns
      d.nv_pending = 1'b0;
      if (q.nv_pending && nv_overload_restore) begin
         d.fault = F_OVERLOAD;
         d.cooling = 1'b1;
         d.cool_cnt = '0;
      end

      // display: frequency in status, cyclic right field, label flash first
      d.status_freq = q.ctrl[CTRL_CLOSED_LOOP];
      if (q.ctrl[CTRL_CLOSED_LOOP] && enter_rise) begin
         case (q.disp)
            D_SETPOINT: d.disp = D_LOAD;
            D_LOAD: d.disp = D_FEEDBACK;
            default: d.disp = D_SETPOINT;
         endcase
         d.flash = q.disp != D_SETPOINT;
         d.flash_cnt = '0;
      end else if (q.flash) begin
         d.flash_cnt = q.flash_cnt + 1'b1;
         if (q.flash_cnt >= FLASH_CYCLES - 1'b1) d.flash = 1'b0;
      end
      case (q.disp)
         D_SETPOINT: d.right_val = q.ref_val;
         D_LOAD: d.right_val = load_percent;
         default: d.right_val = fb;
      endcase
      if (q.flash) d.right_val = 16'h0;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ctrl <= CTRL_RESET;
         q.ramp_time <= RAMP_TIME_RESET;
         q.gains <= GAINS_RESET;
         q.fault <= F_NONE;
         q.rs <= RS_IDLE;
         q.disp <= D_SETPOINT;
         q.nv_pending <= 1'b1;
         q.sync1[PS_EXT_CLOSED] <= 1'b1; // idle closed contact, so no false external trip after reset
         q.sync2[PS_EXT_CLOSED] <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign speed_command = q.speed_cmd;
   assign setpoint_reference = q.ref_val;
   assign drive_stop = q.fault != F_NONE;
   assign fault_code = q.fault;
   assign restart_lockout_state = q.rs == RS_LOCKOUT;
   assign overload_persist = q.fault == F_OVERLOAD;
   assign status_shows_frequency = q.status_freq;
   assign right_field_select = q.disp;
   assign label_flash = q.flash;
   assign right_field_value = q.right_val;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_select_fallback: assert property (!q.sync2[PS_SELECT] |=> q.target == $past(q.keypad_sp))
      else $error("keypad not used with select contact open");
   chk_feedback_conflict: assert property (!src_usable(q.ctrl) |=> !q.analog_used)
      else $error("feedback input used as set point");
   chk_ramp_step: assert property (q.ramp_time != 16'h0 |=>
      (q.ref_val == $past(q.ref_val) || q.ref_val == $past(q.ref_val) + 16'h1 || q.ref_val == $past(q.ref_val) - 16'h1))
      else $error("ramp moved more than one step");
   chk_ramp_bypass: assert property (q.ramp_time == 16'h0 |=> q.ref_val == $past(q.target))
      else $error("zero ramp time did not apply set point");
   chk_sag_no_restart: assert property ((q.fault == F_SAG || q.fault == F_CONTROL) && !fault_reset_req
      |=> q.fault == $past(q.fault))
      else $error("sag or control fault cleared without reset");
   chk_lockout_hold: assert property (q.rs == RS_LOCKOUT && !fault_reset_req |=> q.rs == RS_LOCKOUT)
      else $error("lockout left without manual reset");
   chk_cooling_refuse: assert property (q.fault == F_OVERLOAD && q.cooling |=> q.fault == F_OVERLOAD)
      else $error("overload reset during cooling");
   chk_overcurrent_trip: assert property (q.sync2[PS_OVERCURRENT] && q.fault == F_NONE && !q.nv_pending
      |=> q.fault == F_OVERCURRENT ##1 drive_stop)
      else $error("overcurrent did not trip");
   chk_flash_first: assert property (q.ctrl[CTRL_CLOSED_LOOP] && enter_rise && q.disp == D_LOAD
      |=> q.disp == D_FEEDBACK && q.flash ##1 right_field_value == 16'h0)
      else $error("feedback view without label flash");
endmodule

//--- tb/field_side_model.sv
// field side model: contacts to common, comparator pins, transducers, keypad
// assumes bench requests change just after a rising pclk edge
module field_side_model #(
   parameter logic [15:0] VOLT_VAL = 16'h0800,
   parameter logic [15:0] LOOP_VAL = 16'h0300,
   parameter logic [15:0] LOAD_VAL = 16'h0039,
   parameter logic [15:0] FREQ_VAL = 16'h1000
) (
   input wire logic pclk,
   input wire logic [supervisor_pkg::SYNC_W-1:0] req,
   output logic [supervisor_pkg::SYNC_W-1:0] pins,
   output logic [15:0] volt,
   output logic [15:0] loopv,
   output logic [15:0] load,
   output logic [15:0] freq
);
   timeunit 1ns;
   timeprecision 1ps;
   import supervisor_pkg::*;
   // a closed contact pulls its line to common, so select and external bits invert
   always @(posedge pclk) begin
      pins <= req ^ 13'h0003;
   end
   // transducers hold steady values, driven straight from the parameters with no clocking
   assign volt = VOLT_VAL;
   assign loopv = LOOP_VAL;
   assign load = LOAD_VAL;
   assign freq = FREQ_VAL;
endmodule

//--- tb/drive_setpoint_fault_supervisor_tb_top.sv
// self-checking bench for the set point and fault supervisor
// assumes the package, design and field model are compiled first
module drive_setpoint_fault_supervisor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import supervisor_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nv = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, drive_stop, lockout, persist, freq_shown, flash;
   logic [SYNC_W-1:0] req = 13'h0002;
   logic [SYNC_W-1:0] pins;
   logic [15:0] volt, loopv, freq, load, speed, sp_ref, rval, s1;
   fault_t fault;
   disp_t sel;
   int errors = 0, num_checks = 0, cycles = 0;
   logic [7:0] ra[4] = '{ADDR_CTRL, ADDR_KEYPAD_SP, ADDR_RAMP_TIME, ADDR_GAINS};
   logic [31:0] rv[4] = '{32'h10, 32'h0, 32'h12c, 32'h10};
   logic [31:0] sc[4] = '{32'h12, 32'h1c, 32'h14, 32'h1a};
   logic [31:0] sx[4] = '{32'h1234, 32'h1234, 32'h0300, 32'h0800};
   logic [31:0] rt[2] = '{32'h1236, 32'h1233};
   logic [31:0] dv[3] = '{32'h1233, 32'h0039, 32'h0800};
   int fp[8] = '{PS_OVERCURRENT, PS_UNDERVOLT, PS_OVERVOLT, PS_SAG, PS_EXT_CLOSED, PS_LOOP_LOW, PS_LANGUAGE, PS_BRAKE};
   fault_t fc[8] = '{F_OVERCURRENT, F_UNDERVOLT, F_OVERVOLT, F_SAG, F_EXTERNAL, F_LOOP_LOSS, F_LANGUAGE, F_BRAKE};
   // short counts so restart, cooling and flash fit in one run
   drive_setpoint_fault_supervisor #(.RESTART_WAIT_CYCLES(36'd200), .COOL_CYCLES(36'd150),
      .ATTEMPT_CYCLES(36'd50), .FLASH_CYCLES(32'd20), .PID_TICK_CYCLES(32'd10)) dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .setpoint_select_contact_n(pins[PS_SELECT]), .external_fault_contact_n(pins[PS_EXT_CLOSED]),
      .overcurrent_detect(pins[PS_OVERCURRENT]), .bus_undervoltage_detect(pins[PS_UNDERVOLT]),
      .bus_overvoltage_detect(pins[PS_OVERVOLT]), .current_loop_below_2ma(pins[PS_LOOP_LOW]),
      .control_supply_sag_detect(pins[PS_SAG]), .brake_resistor_overload(pins[PS_BRAKE]),
      .overload_detect(pins[PS_OVERLOAD]), .enter_key(pins[PS_ENTER]),
      .output_below_1p5hz(pins[PS_LOW_FREQ]), .software_version_mismatch(pins[PS_SW_MISMATCH]),
      .language_missing(pins[PS_LANGUAGE]), .voltage_analog_input(volt), .current_loop_input(loopv),
      .output_frequency(freq), .load_percent(load), .nv_overload_restore(nv), .speed_command(speed),
      .setpoint_reference(sp_ref), .drive_stop, .fault_code(fault), .restart_lockout_state(lockout),
      .overload_persist(persist), .status_shows_frequency(freq_shown), .right_field_select(sel),
      .label_flash(flash), .right_field_value(rval));
   field_side_model field (.pclk, .req, .pins, .volt, .loopv, .load, .freq);
   always #2 pclk = ~pclk;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one transfer; request held until pready is seen high, then one idle edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic freset();
      apb(1'b1, ADDR_CMD, 32'h1);
      cyc(3);
   endtask
   task automatic chk_fault(input fault_t c);
      chk("fault_code", 32'(fault), 32'(c));
      chk("drive_stop", 32'(drive_stop), 32'(c != F_NONE));
   endtask
   // pulse one field line away from its idle level and back
   task automatic trip(input int p);
      req[p] <= ~req[p];
      cyc(8);
      req[p] <= ~req[p];
      cyc(4);
   endtask
   // a hang ends in the closing report
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 12000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      cyc(20);
      presetn <= 1'b1;
      cyc(2);
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset value", rdat, rv[i]);
      end
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped error", 32'(rerr), 32'h1);
      apb(1'b1, ADDR_RAMP_TIME, 32'h0);
      apb(1'b1, ADDR_KEYPAD_SP, 32'h1234);
      cyc(4);
      chk("setpoint_reference", 32'(sp_ref), 32'h1234);
      req[PS_SELECT] <= 1'b1;
      foreach (sc[i]) begin
         apb(1'b1, ADDR_CTRL, sc[i]);
         cyc(8);
         chk("setpoint_reference", 32'(sp_ref), sx[i]);
      end
      req[PS_SELECT] <= 1'b0;
      cyc(8);
      chk("setpoint_reference", 32'(sp_ref), 32'h1234);
      apb(1'b1, ADDR_RAMP_TIME, 32'h1);
      foreach (rt[i]) begin
         apb(1'b1, ADDR_KEYPAD_SP, rt[i]);
         cyc(20);
         chk("ramp under way", 32'(sp_ref != rt[i][15:0]), 32'h1);
         cyc(1200);
         chk("setpoint_reference", 32'(sp_ref), rt[i]);
      end
      apb(1'b1, ADDR_GAINS, 32'h100);
      apb(1'b1, ADDR_CTRL, 32'h11);
      cyc(50);
      s1 = speed;
      cyc(100);
      chk("speed rising", 32'(speed > s1), 32'h1);
      chk("status_shows_frequency", 32'(freq_shown), 32'h1);
      for (int i = 1; i <= 3; i++) begin
         req[PS_ENTER] <= 1'b1;
         cyc(6);
         req[PS_ENTER] <= 1'b0;
         cyc(6);
         chk("right_field_select", 32'(sel), 32'(i % 3));
         chk("label_flash", 32'(flash), 32'(i != 1));
         cyc(20);
         chk("right_field_value", 32'(rval), dv[i % 3]);
      end
      // derivative only: a step in error must leave the settled command unchanged
      apb(1'b1, ADDR_GAINS, 32'h10000);
      cyc(30);
      s1 = speed;
      apb(1'b1, ADDR_CTRL, 32'h19);
      cyc(30);
      chk("speed_command", 32'(speed), 32'(s1));
      foreach (fp[i]) begin
         trip(fp[i]);
         cyc(fc[i] == F_SAG ? 260 : 8);
         chk_fault(fc[i]);
         freset();
         chk_fault(F_NONE);
      end
      apb(1'b1, ADDR_CTRL, 32'h30);
      cyc(8);
      chk_fault(F_EXTERNAL);
      req[PS_EXT_CLOSED] <= 1'b0;
      cyc(8);
      freset();
      chk_fault(F_NONE);
      trip(PS_OVERLOAD);
      freset();
      chk_fault(F_OVERLOAD);
      chk("overload_persist", 32'(persist), 32'h1);
      cyc(160);
      freset();
      chk_fault(F_NONE);
      trip(PS_SW_MISMATCH);
      freset();
      chk_fault(F_CONTROL);
      apb(1'b1, ADDR_CMD, 32'h2);
      freset();
      chk_fault(F_NONE);
      req[PS_LOW_FREQ] <= 1'b1;
      trip(PS_OVERCURRENT);
      cyc(100);
      chk_fault(F_OVERCURRENT);
      cyc(100);
      chk_fault(F_NONE);
      trip(PS_OVERCURRENT);
      chk_fault(F_OVERCURRENT);
      cyc(300);
      chk("restart_lockout_state", 32'(lockout), 32'h1);
      freset();
      chk("restart_lockout_state", 32'(lockout), 32'h0);
      req <= 13'h0002;
      nv <= 1'b1;
      presetn <= 1'b0;
      cyc(2);
      presetn <= 1'b1;
      cyc(4);
      nv <= 1'b0;
      chk_fault(F_OVERLOAD);
      freset();
      chk_fault(F_OVERLOAD);
      cyc(160);
      freset();
      chk_fault(F_NONE);
      end_of_test();
   end
endmodule
